//--- dns_map.vh
// Constants for the null-write DMA channel block.
`ifndef DNS_MAP_VH
`define DNS_MAP_VH
`define DNS_MODE_PINGPONG_BIT 1
`define DNS_NULL_WORD 16'h0000
`define DNS_NULL_BYTE 16'h0000
`define DNS_ADDR_W 11
`define DNS_CNT_W 10
`define DNS_DATA_W 16
`define DNS_ZERO_ADDR 11'h000
`define DNS_ZERO_CNT 10'h000
`endif

//--- dns_chan.v
// Single DMA channel with null-data-write mode and transfer start control.
// Summary of operation
// - Null write zero to peripheral on peripheral read.
// - Null write coincides with RAM write.
// - Null write on requested and forced transfers alike.
// - Forced start reads invalid data, advances pointer.
// - No transfer until channel enabled.
// - Enable toggle zeroes count, selects primary.
// - Transfer starts on peripheral request.
// - SPI slave RX request on first data.
// - UART receiver request on received character.
// - Lost UART request restarted by trigger.
// - Trigger cleared only by hardware on completion.
// - Mode 1x ping-pong, 0x continuous.
// - Trigger during pending request sets both collisions.
`include "dns_map.vh"
module dns_chan (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire        channel_enable,
	input  wire        null_write_select,
	input  wire        dir_ram_to_periph,
	input  wire        size_byte,
	input  wire [1:0]  mode_sel,
	input  wire        one_shot,
	input  wire [9:0]  block_count,
	input  wire [10:0] primary_buffer_offset,
	input  wire [10:0] secondary_buffer_offset,
	input  wire        force_set,
	input  wire        periph_req,
	input  wire        coll_clear,
	input  wire [15:0] periph_rdata,
	input  wire [15:0] ram_rdata,
	input  wire        out_ready,
	output reg         force_pending,
	output reg         ram_write_collision_flag,
	output reg         periph_write_collision_flag,
	output reg         periph_req_ack,
	output reg         out_valid,
	output reg         out_ram_we,
	output reg  [10:0] out_ram_addr,
	output reg  [15:0] out_ram_wdata,
	output reg         out_periph_we,
	output reg  [15:0] out_periph_wdata,
	output reg         out_periph_byte,
	output reg         out_periph_re,
	output reg         out_ram_re,
	output reg         active_secondary,
	output reg         block_done
);
	// Synchronised copies of the peripheral request and its served mask.
	reg        req_s1_q;
	reg        req_s2_q;
	reg        req_seen_q;
	wire       req_live;
	reg        en_q;
	reg [9:0]  count_q;
	reg [10:0] ptr_q;
	// Two-entry buffer storage for bus beats.
	reg        b_we_q [0:1];
	reg [10:0] b_ad_q [0:1];
	reg [15:0] b_wd_q [0:1];
	reg        b_pwe_q [0:1];
	reg [15:0] b_pwd_q [0:1];
	reg        b_by_q [0:1];
	reg        b_pre_q [0:1];
	reg        b_rre_q [0:1];
	reg        wr_q;
	reg        rd_q;
	reg [1:0]  fill_q;
	wire       buf_ready;
	wire       pop;
	wire       chan_live;
	wire       fire;
	wire       coll_any;
	wire       last;
	wire [10:0] base;

	// Selects the start offset of the active buffer.
	function [10:0] dns_base;
		input        sec;
		input [10:0] a;
		input [10:0] b;
		begin
			dns_base = sec ? b : a;
		end
	endfunction

	assign buf_ready = (fill_q != 2'd2);
	assign pop       = out_valid & out_ready;
	assign chan_live = en_q & channel_enable;
	assign coll_any  = ram_write_collision_flag | periph_write_collision_flag;
	// A transfer fires on a request or a trigger, stalled by a full buffer.
	assign fire      = chan_live & ~coll_any & buf_ready & (req_live | force_pending);
	// A request already served is masked until its line drops through the synchroniser.
	assign req_live  = req_s2_q & ~req_seen_q;
	assign last      = (count_q == block_count);
	assign base      = dns_base(active_secondary, primary_buffer_offset, secondary_buffer_offset);

	// Request synchroniser.
	always @(posedge clk_sys) begin
		if (rst) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_seen_q <= 1'b0;
		end else begin
			req_s1_q <= periph_req;
			req_s2_q <= req_s1_q;
			// Without this mask the synchroniser delay would refire one request.
			if (!req_s2_q) begin
				req_seen_q <= 1'b0;
			end else if (fire & req_live) begin
				req_seen_q <= 1'b1;
			end
		end
	end

	// Channel state: enable edge, count, pointer, buffer choice, trigger and flags.
	always @(posedge clk_sys) begin
		if (rst) begin
			en_q <= 1'b0;
			count_q <= `DNS_ZERO_CNT;
			ptr_q <= `DNS_ZERO_ADDR;
			active_secondary <= 1'b0;
			force_pending <= 1'b0;
			ram_write_collision_flag <= 1'b0;
			periph_write_collision_flag <= 1'b0;
			periph_req_ack <= 1'b0;
			block_done <= 1'b0;
		end else begin
			en_q <= channel_enable;
			periph_req_ack <= fire & req_live;
			block_done <= fire & last;
			if (channel_enable & ~en_q) begin
				count_q <= `DNS_ZERO_CNT;
				ptr_q <= primary_buffer_offset;
				active_secondary <= 1'b0;
			end else if (fire) begin
				if (last) begin
					count_q <= `DNS_ZERO_CNT;
					// Ping-pong alternates buffers, continuous returns to primary.
					if (mode_sel[`DNS_MODE_PINGPONG_BIT]) begin
						active_secondary <= ~active_secondary;
						ptr_q <= active_secondary ? primary_buffer_offset : secondary_buffer_offset;
					end else begin
						active_secondary <= 1'b0;
						ptr_q <= primary_buffer_offset;
					end
				end else begin
					count_q <= count_q + 10'd1;
					ptr_q <= ptr_q + (size_byte ? 11'd1 : 11'd2);
				end
			end
			// The trigger clears only when its forced transfer completes.
			if (force_set & req_live) begin
				force_pending <= force_pending;
			end else if (fire & ~req_live) begin
				force_pending <= 1'b0;
			end else if (force_set & chan_live) begin
				force_pending <= 1'b1;
			end
			// A trigger against a pending request sets both flags; set beats clear.
			if (force_set & req_live) begin
				ram_write_collision_flag <= 1'b1;
				periph_write_collision_flag <= 1'b1;
			end else if (coll_clear) begin
				ram_write_collision_flag <= 1'b0;
				periph_write_collision_flag <= 1'b0;
			end
			if (one_shot & fire & last & mode_sel[`DNS_MODE_PINGPONG_BIT] & active_secondary) begin
				en_q <= 1'b0;
			end
		end
	end

	// Buffer write and read pointers with occupancy.
	always @(posedge clk_sys) begin
		if (rst) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			fill_q <= 2'd0;
		end else begin
			if (fire) wr_q <= ~wr_q;
			if (pop) rd_q <= ~rd_q;
			fill_q <= fill_q + {1'b0, fire} - {1'b0, pop};
		end
	end

	// Loads one bus beat; null write rides with the RAM write.
	always @(posedge clk_sys) begin
		if (fire) begin
			b_ad_q[wr_q]  <= ptr_q;
			b_by_q[wr_q]  <= size_byte;
			if (dir_ram_to_periph) begin
				b_we_q[wr_q]  <= 1'b0;
				b_wd_q[wr_q]  <= `DNS_NULL_WORD;
				b_rre_q[wr_q] <= 1'b1;
				b_pre_q[wr_q] <= 1'b0;
				b_pwe_q[wr_q] <= 1'b1;
				b_pwd_q[wr_q] <= ram_rdata;
			end else begin
				b_we_q[wr_q]  <= 1'b1;
				b_wd_q[wr_q]  <= periph_rdata;
				b_rre_q[wr_q] <= 1'b0;
				b_pre_q[wr_q] <= 1'b1;
				b_pwe_q[wr_q] <= null_write_select;
				b_pwd_q[wr_q] <= size_byte ? `DNS_NULL_BYTE : `DNS_NULL_WORD;
			end
		end
	end

	// Registered output stage presenting the head of the buffer.
	always @(posedge clk_sys) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_ram_we <= 1'b0;
			out_ram_addr <= `DNS_ZERO_ADDR;
			out_ram_wdata <= `DNS_NULL_WORD;
			out_periph_we <= 1'b0;
			out_periph_wdata <= `DNS_NULL_WORD;
			out_periph_byte <= 1'b0;
			out_periph_re <= 1'b0;
			out_ram_re <= 1'b0;
		end else begin
			if (!out_valid || pop) begin
				out_valid <= (fill_q != 2'd0) && !(pop && fill_q == 2'd1) && !(!out_valid && 1'b0);
			end
			out_ram_we       <= b_we_q[rd_q ^ pop];
			out_ram_addr     <= b_ad_q[rd_q ^ pop];
			out_ram_wdata    <= b_wd_q[rd_q ^ pop];
			out_periph_we    <= b_pwe_q[rd_q ^ pop];
			out_periph_wdata <= b_pwd_q[rd_q ^ pop];
			out_periph_byte  <= b_by_q[rd_q ^ pop];
			out_periph_re    <= b_pre_q[rd_q ^ pop];
			out_ram_re       <= b_rre_q[rd_q ^ pop];
		end
	end
endmodule

//--- dns_chan_sva.sv
// Concurrent checks on the ports of the null-write DMA channel.
module dns_chan_sva (
	input logic        clk_sys,
	input logic        rst,
	input logic        channel_enable,
	input logic        size_byte,
	input logic [1:0]  mode_sel,
	input logic        periph_req,
	input logic        force_pending,
	input logic        ram_write_collision_flag,
	input logic        periph_write_collision_flag,
	input logic        periph_req_ack,
	input logic        out_valid,
	input logic        out_ram_we,
	input logic        out_periph_we,
	input logic [15:0] out_periph_wdata,
	input logic        out_periph_byte,
	input logic        out_periph_re,
	input logic        active_secondary
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// A beat that carries a write back to the peripheral.
	sequence s_null;
		out_valid && out_periph_we;
	endsequence
	// A fresh request while the channel can take it.
	sequence s_ask;
		$rose(periph_req) && channel_enable && !ram_write_collision_flag;
	endsequence
	a_null_zero: assert property (s_null |-> out_periph_wdata == 16'h0000)
		else $error("null write data not zero");
	a_null_pair: assert property (s_null |-> out_ram_we && out_periph_re)
		else $error("null write without read and store");
	a_null_size: assert property (s_null |-> out_periph_byte == size_byte)
		else $error("null write size wrong");
	a_off_quiet: assert property (!channel_enable |-> ##2 !periph_req_ack)
		else $error("transfer while disabled");
	a_req_served: assert property (s_ask |-> ##[1:40] (periph_req_ack || !channel_enable
		|| ram_write_collision_flag)) else $error("request not served");
	a_force_clears: assert property ($rose(force_pending) |-> ##[1:40] !force_pending)
		else $error("trigger never cleared");
	a_flags_twin: assert property (ram_write_collision_flag == periph_write_collision_flag)
		else $error("collision flags differ");
	a_cont_primary: assert property (!mode_sel[1] && !active_secondary |=> !active_secondary)
		else $error("continuous mode left primary");
endmodule
bind dns_chan dns_chan_sva u_sva (.*);

//--- dns_periph.sv
// Model of a receiving serial peripheral that raises transfer requests.
module dns_periph (
	input  logic        clk_sys,
	input  logic        rst,
	input  logic        go,
	input  logic        periph_req_ack,
	output logic        periph_req = 1'h0,
	output logic [15:0] periph_rdata = 16'hA5A5
);
	timeunit 1ns;
	timeprecision 100ps;
	// A received word raises the request, which stands until acknowledged.
	always @(posedge clk_sys) begin
		if (rst || periph_req_ack)
			periph_req <= 1'h0;
		else if (go)
			periph_req <= 1'h1;
		// Data lines wander while no word waits, so stale values never match.
		if (!periph_req)
			periph_rdata <= periph_rdata + 16'h3C5B;
	end
endmodule

//--- dns_tb.sv
// Self-checking bench for the null-write DMA channel.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_sys = 0, rst = 1, channel_enable = 0, null_write_select = 0, size_byte = 0;
	logic        dir_ram_to_periph = 0, one_shot = 0, force_set = 0, coll_clear = 0;
	logic        out_ready = 0, go = 0, hold = 0;
	logic [1:0]  mode_sel = 0;
	logic [9:0]  block_count = 10'h003;
	logic [10:0] primary_buffer_offset = 11'h100, secondary_buffer_offset = 11'h200;
	logic [15:0] ram_rdata = 16'h0000;
	wire         periph_req, force_pending, ram_write_collision_flag, periph_write_collision_flag;
	wire         periph_req_ack, out_valid, out_ram_we, out_periph_we, out_periph_byte;
	wire         out_periph_re, out_ram_re, active_secondary, block_done;
	wire [10:0]  out_ram_addr;
	wire [15:0]  out_ram_wdata, out_periph_wdata, periph_rdata;
	integer      seed = 86972, bad_count = 0, checks_done = 0, cyc = 0, cnt = 0, sec = 0, i;
	logic [29:0] q[$];
	dns_chan u_dut (.*);
	dns_periph u_per (.*);
	initial forever #2 clk_sys = ~clk_sys;
	task wrap_up;
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [29:0] s, input logic [29:0] x);
		checks_done = checks_done + 1;
		if (s !== x) begin
			bad_count = bad_count + 1;
			$display("wrong value at %0t: saw %h expected %h", $time, s, x);
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk_sys);
	endtask
	// Notes the next beat: address walks the active buffer and wraps per block.
	task push;
		q.push_back({1'h1, null_write_select, null_write_select & size_byte, 16'h0000,
			11'((sec ? secondary_buffer_offset : primary_buffer_offset) + cnt * (size_byte ? 1 : 2))});
		cnt = (cnt == block_count) ? 0 : cnt + 1;
		if (cnt == 0 && mode_sel[1])
			sec = !sec;
	endtask
	task req(input logic raise);
		push;
		if (raise) begin
			@(posedge clk_sys) go <= 1;
			@(posedge clk_sys) go <= 0;
		end
		for (i = 0; i < 100 && periph_req_ack !== 1'h1; i++)
			tick(1);
	endtask
	// Toggling the enable restarts the count in the primary buffer.
	task cfg(input logic nw, input logic byt, input logic [1:0] m, input logic [9:0] bc);
		@(posedge clk_sys) channel_enable <= 0;
		null_write_select <= nw;
		size_byte <= byt;
		mode_sel <= m;
		block_count <= bc;
		@(posedge clk_sys) channel_enable <= 1;
		cnt = 0;
		sec = 0;
		tick(2);
	endtask
	// Random receiver stalls; a hold freezes it so the buffer fills.
	always @(posedge clk_sys) begin
		out_ready <= !hold && ($random(seed) % 4 != 0);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			wrap_up;
		end
	end
	// Each accepted beat is compared with the oldest note.
	always @(posedge clk_sys) if (!rst && out_valid && out_ready) begin
		chk({out_ram_we, out_periph_we, out_periph_we & out_periph_byte, out_periph_we ?
			out_periph_wdata : 16'h0000, out_ram_addr}, q.size() ? q.pop_front() : 30'h0);
	end
	initial begin
		tick(12);
		rst <= 0;
		@(posedge clk_sys) go <= 1;
		@(posedge clk_sys) go <= 0;
		tick(10);
		cfg(1, 0, 2'h0, 10'h003);
		req(0);
		push;
		@(posedge clk_sys) force_set <= 1;
		@(posedge clk_sys) force_set <= 0;
		for (i = 0; i < 40 && force_pending !== 1'h0; i++)
			tick(1);
		repeat (6) req(1);
		cfg(1, 0, 2'h2, 10'h002);
		repeat (8) req(1);
		cfg(0, 1, 2'h0, 10'h001);
		repeat (3) req(1);
		// Drain first so the held buffer takes exactly the two beats below.
		for (i = 0; i < 200 && q.size() != 0; i++)
			tick(1);
		tick(4);
		hold <= 1;
		repeat (2) req(1);
		push;
		@(posedge clk_sys) go <= 1;
		@(posedge clk_sys) go <= 0;
		tick(4);
		@(posedge clk_sys) force_set <= 1;
		@(posedge clk_sys) force_set <= 0;
		tick(3);
		chk({ram_write_collision_flag, periph_write_collision_flag}, 30'h3);
		@(posedge clk_sys) coll_clear <= 1;
		@(posedge clk_sys) coll_clear <= 0;
		tick(2);
		chk({ram_write_collision_flag, periph_write_collision_flag}, 30'h0);
		hold <= 0;
		for (i = 0; i < 200 && q.size() != 0; i++)
			tick(1);
		chk(30'(q.size()), 30'h0);
		wrap_up;
	end
endmodule
